/* File: cpu_interrupt_exception_dispatch.sv */
/*
 * interrupt and exception dispatch: selects a vector, saves state, reads the
 * handler entry and starts the handler.
 * assumes the core gives boundary strobes, done handshakes for the stack push
 * and table read, and that the controller holds its vector before ackValid.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1 - 256 sources, each an 8-bit vector
// RQ2 - entry is 4 bytes real, 8 protected
// RQ3 - vectors 0 to 31 reserved, 224 free
// RQ4 - push state, get vector, fetch, then run
// RQ5 - vector internal, in instruction, or from ack
// RQ6 - maskable taken only with flag set
// RQ7 - external only at boundaries or string moves
// RQ8 - return past interrupt, at faulting instruction
// RQ9 - faults dispatched before the instruction executes
// RQ10 - traps dispatched after the instruction completes
// RQ11 - aborts dispatched without a precise location
// RQ12 - fixed fault vectors for internal exceptions
// RQ13 - vector 8 double fault is an abort
// RQ14 - vector 1 debug, trap and fault together
// RQ15 - clear flag on entry, return restores it
// RQ16 - non-maskable uses vector 2, no ack
// RQ17 - one non-maskable held until the return
// RQ18 - non-maskable entry clears the enable flag
// RQ19 - non-maskable first, then maskable if enabled
// RQ20 - software interrupt n dispatches vector n
// RQ21 - breakpoint traps to 3, overflow to 4
// RQ22 - debug, then external, then fetch faults
// RQ23 - fault invoking segment handler gives 8
// RQ24 - controller holds request until acknowledged
module cpu_interrupt_exception_dispatch
	import irq_dispatch_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        resetn,
	input  wire logic                        nmiIn,
	input  wire logic                        maskableIrqIn,
	input  wire logic                        ackValid,
	input  wire logic [7:0]                  ackVector,
	input  wire logic                        instrBoundary,
	input  wire logic                        stringWindow,
	input  wire logic                        realMode,
	input  wire logic [31:0]                 tableBase,
	input  wire logic [31:0]                 instrAddr,
	input  wire logic [31:0]                 nextInstrAddr,
	input  wire logic                        debugTrap,
	input  wire logic                        debugFault,
	input  wire logic                        excReq,
	input  wire logic [7:0]                  excVector,
	input  wire logic                        swIntReq,
	input  wire logic [7:0]                  swIntVector,
	input  wire logic                        breakpointInstr,
	input  wire logic                        overflowInstr,
	input  wire logic                        overflowFlag,
	input  wire logic                        deliveryFault,
	input  wire logic [7:0]                  deliveryVector,
	input  wire logic                        pushDone,
	input  wire logic                        fetchDone,
	input  wire logic                        interruptReturnInstr,
	input  wire logic                        restoredIf,
	input  wire logic                        ifWrite,
	input  wire logic                        ifWriteValue,
	output logic                             pushReq,
	output logic [31:0]                      returnAddr,
	output logic                             savedIf,
	output logic                             ackReq,
	output logic                             fetchReq,
	output logic [31:0]                      fetchAddr,
	output logic                             dispatchValid,
	output logic [7:0]                       dispatchVector,
	output irq_dispatch_pkg::class_e         dispatchClass,
	output logic                             ifFlag,
	output logic                             nmiActive,
	output logic                             reservedVector
);

	import irq_dispatch_pkg::*;

	state_e      state_reg;
	state_e      state_next;
	logic        nmiSync;
	logic        irqSync;
	logic        ackValidSync;
	logic [7:0]  ackVectorSync;
	logic        nmiPrev_reg;
	logic        nmiPending_reg;
	logic        needsAck_reg;
	logic        needsAck_next;
	logic [7:0]  vector_next;
	class_e      class_next;
	logic [31:0] retAddr_next;
	logic        pickValid;
	logic [7:0]  pickVector;
	class_e      pickClass;
	logic        pickNeedsAck;

	// pins and controller lines, two stages each
	sync_two_ff #(
		.WIDTH(3 + VEC_W)
	) pinSync (
		.core_clk(core_clk),
		.resetn  (resetn),
		.asyncIn ({nmiIn, maskableIrqIn, ackValid, ackVector}),
		.syncOut ({nmiSync, irqSync, ackValidSync, ackVectorSync})
	);

	wire idle     = state_reg == ST_IDLE;
	wire extPoint = idle && (instrBoundary || stringWindow); // RQ7
	wire insPoint = idle && instrBoundary; // RQ9

	// one rising edge is held while a handler runs
	wire nmiRise = nmiSync && !nmiPrev_reg;
	wire nmiTake = extPoint && nmiPending_reg && !nmiActive; // RQ17

	// the request must still stand at the boundary to be seen
	wire intrTake = extPoint && irqSync && ifFlag; // RQ6 RQ24

	wire ofTrap = overflowInstr && overflowFlag;

	event_prioritiser prio (
		.debugTrap      (insPoint && debugTrap),
		.debugFault     (insPoint && debugFault),
		.nmiTake        (nmiTake),
		.intrTake       (intrTake),
		.excReq         (insPoint && excReq),
		.excVector      (excVector),
		.swIntReq       (insPoint && swIntReq),
		.swIntVector    (swIntVector),
		.breakpointInstr(insPoint && breakpointInstr),
		.overflowTrap   (insPoint && ofTrap),
		.pickValid      (pickValid),
		.pickVector     (pickVector),
		.pickClass      (pickClass),
		.pickNeedsAck   (pickNeedsAck)
	);

	wire take = idle && pickValid;
	wire takeNmi = take && pickClass == CLS_NMI;

	// faults restart the instruction with its prefixes, others resume past it
	wire [31:0] pickRet = (pickClass == CLS_FAULT) ?
		instrAddr : nextInstrAddr; // RQ8

	// nested fault while pushing the frame or reading the entry
	wire delivering = state_reg == ST_PUSH || state_reg == ST_FETCH;
	wire segInvoke = dispatchVector >= VEC_BAD_TASK &&
		dispatchVector <= VEC_GEN_PROT;
	wire pageInvoke = dispatchVector == VEC_PAGE;
	wire nestedFault = delivering && deliveryFault;
	wire doubleFault = nestedFault && deliveryVector != VEC_PAGE &&
		(segInvoke || pageInvoke); // RQ23

	// entry address is base plus vector times entry size
	wire [31:0] vectorWide  = {24'h000000, dispatchVector}; // RQ1
	wire [31:0] realOffset  = vectorWide << ENTRY_SHIFT_REAL;
	wire [31:0] protOffset  = vectorWide << ENTRY_SHIFT_PROT;
	wire [31:0] entryOffset = realMode ? realOffset : protOffset; // RQ2

	// dispatch sequence: push, optional ack, entry read, start
	always_comb begin
		state_next    = state_reg;
		needsAck_next = needsAck_reg;
		vector_next   = dispatchVector;
		class_next    = dispatchClass;
		retAddr_next  = returnAddr;
		case (state_reg)
			ST_IDLE: begin
				if (take) begin
					state_next    = ST_PUSH;
					needsAck_next = pickNeedsAck;
					vector_next   = pickVector;
					class_next    = pickClass;
					retAddr_next  = pickRet;
				end
			end
			ST_PUSH: begin
				if (nestedFault) begin
					state_next    = ST_PUSH;
					needsAck_next = 1'b0;
					vector_next   = doubleFault ? VEC_DOUBLE : deliveryVector; // RQ13
					class_next    = doubleFault ? CLS_ABORT :
						vec_class(deliveryVector); // RQ11
				end else if (pushDone) begin
					state_next = needsAck_reg ? ST_ACK : ST_FETCH; // RQ4
				end
			end
			ST_ACK: begin
				if (ackValidSync) begin
					state_next  = ST_FETCH;
					vector_next = ackVectorSync; // RQ5
				end
			end
			ST_FETCH: begin
				if (nestedFault) begin
					state_next    = ST_PUSH;
					needsAck_next = 1'b0;
					vector_next   = doubleFault ? VEC_DOUBLE : deliveryVector; // RQ13
					class_next    = doubleFault ? CLS_ABORT :
						vec_class(deliveryVector); // RQ11
				end else if (fetchDone) begin
					state_next = ST_ENTER; // RQ4
				end
			end
			ST_ENTER: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg      <= ST_IDLE;
			needsAck_reg   <= 1'b0;
			dispatchVector <= 8'h00;
			dispatchClass  <= CLS_FAULT;
			returnAddr     <= 32'h00000000;
		end else begin
			state_reg      <= state_next;
			needsAck_reg   <= needsAck_next;
			dispatchVector <= vector_next;
			dispatchClass  <= class_next;
			returnAddr     <= retAddr_next;
		end
	end

	// handshake levels follow the next state, straight from flip-flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pushReq       <= 1'b0;
			ackReq        <= 1'b0;
			fetchReq      <= 1'b0;
			fetchAddr     <= 32'h00000000;
			dispatchValid <= 1'b0;
		end else begin
			pushReq       <= state_next == ST_PUSH; // RQ4
			ackReq        <= state_next == ST_ACK;
			fetchReq      <= state_next == ST_FETCH;
			fetchAddr     <= tableBase + entryOffset;
			dispatchValid <= state_next == ST_ENTER;
		end
	end

	// flag value saved with the frame is the one before entry
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			savedIf <= 1'b0;
		end else if (take) begin
			savedIf <= ifFlag; // RQ15
		end
	end

	// flag priority: entry, then return, then software write
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ifFlag <= 1'b0;
		end else if (take) begin
			ifFlag <= 1'b0; // RQ15 RQ18 RQ19
		end else if (interruptReturnInstr) begin
			ifFlag <= restoredIf; // RQ15
		end else if (ifWrite) begin
			ifFlag <= ifWriteValue;
		end
	end

	// a new edge in the take cycle is kept, set wins over clear
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			nmiPrev_reg    <= 1'b0;
			nmiPending_reg <= 1'b0;
		end else begin
			nmiPrev_reg    <= nmiSync;
			nmiPending_reg <= nmiRise || (nmiPending_reg && !takeNmi); // RQ17
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			nmiActive <= 1'b0;
		end else if (takeNmi) begin
			nmiActive <= 1'b1; // RQ16
		end else if (interruptReturnInstr) begin
			nmiActive <= 1'b0; // RQ17
		end
	end

	// controller answered with a vector from the reserved range
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reservedVector <= 1'b0;
		end else if (state_reg == ST_ACK && ackValidSync) begin
			reservedVector <= ackVectorSync < VEC_FIRST_USER; // RQ3
		end
	end

endmodule

`default_nettype wire

/* File: irq_dispatch_pkg.sv */
/*
 * constants and types shared by the interrupt and exception dispatch unit.
 * assumes an 8-bit vector space and a 32-bit linear address space.
 */
package irq_dispatch_pkg;

	localparam int VEC_W     = 8;
	localparam int ADDR_W    = 32;
	localparam int NUM_VECS  = 256;
	localparam int RSVD_VECS = 32;

	localparam logic [7:0] VEC_DIVIDE     = 8'h00;
	localparam logic [7:0] VEC_DEBUG      = 8'h01;
	localparam logic [7:0] VEC_NMI        = 8'h02;
	localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
	localparam logic [7:0] VEC_OVERFLOW   = 8'h04;
	localparam logic [7:0] VEC_BOUNDS     = 8'h05;
	localparam logic [7:0] VEC_OPCODE     = 8'h06;
	localparam logic [7:0] VEC_NO_COPRO   = 8'h07;
	localparam logic [7:0] VEC_DOUBLE     = 8'h08;
	localparam logic [7:0] VEC_BAD_TASK   = 8'h0a;
	localparam logic [7:0] VEC_NOT_PRES   = 8'h0b;
	localparam logic [7:0] VEC_STACK      = 8'h0c;
	localparam logic [7:0] VEC_GEN_PROT   = 8'h0d;
	localparam logic [7:0] VEC_PAGE       = 8'h0e;
	localparam logic [7:0] VEC_FPU_ERR    = 8'h10;
	localparam logic [7:0] VEC_ALIGN      = 8'h11;
	localparam logic [7:0] VEC_FIRST_USER = 8'h20;

	// table entry size as a shift of the vector: 4 bytes real, 8 protected
	localparam int ENTRY_SHIFT_REAL = 2;
	localparam int ENTRY_SHIFT_PROT = 3;

	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		CLS_FAULT,
		CLS_TRAP,
		CLS_ABORT,
		CLS_MASKABLE_IRQ_IN,
		CLS_NMI
	} class_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH,
		ST_ACK,
		ST_FETCH,
		ST_ENTER
	} state_e;

	// class of an internally raised exception vector
	function automatic class_e vec_class(input logic [7:0] v);
		if (v == VEC_DOUBLE)
			return CLS_ABORT;
		else if (v == VEC_DIVIDE || v == VEC_BOUNDS || v == VEC_OPCODE ||
			v == VEC_NO_COPRO || (v >= VEC_BAD_TASK && v <= VEC_PAGE) ||
			v == VEC_FPU_ERR || v == VEC_ALIGN)
			return CLS_FAULT;
		else
			return CLS_TRAP;
	endfunction

endpackage

/* File: sync_two_ff.sv */
/*
 * two flip-flop synchroniser for a group of pin levels.
 * assumes each bit changes slowly against core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sync_two_ff #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end

endmodule

`default_nettype wire

/* File: event_prioritiser.sv */
/*
 * picks the one event to dispatch at a boundary, with its vector and class.
 * assumes requests are already gated by boundary and enable conditions.
 */
`timescale 1ns/1ps
`default_nettype none

module event_prioritiser
	import irq_dispatch_pkg::*;
(
	input  wire logic                         debugTrap,
	input  wire logic                         debugFault,
	input  wire logic                         nmiTake,
	input  wire logic                         intrTake,
	input  wire logic                         excReq,
	input  wire logic [7:0]                   excVector,
	input  wire logic                         swIntReq,
	input  wire logic [7:0]                   swIntVector,
	input  wire logic                         breakpointInstr,
	input  wire logic                         overflowTrap,
	output logic                              pickValid,
	output logic [7:0]                        pickVector,
	output irq_dispatch_pkg::class_e          pickClass,
	output logic                              pickNeedsAck
);

	import irq_dispatch_pkg::*;

	wire debugAny = debugTrap | debugFault;

	// debug traps, debug faults, nmi, maskable_irq_in, then decode faults, then traps
	assign pickValid = debugAny | nmiTake | intrTake | excReq | swIntReq |
		breakpointInstr | overflowTrap; // RQ22

	assign pickVector =
		debugAny        ? VEC_DEBUG :      // RQ14
		nmiTake         ? VEC_NMI :        // RQ16
		intrTake        ? 8'h00 :
		excReq          ? excVector :      // RQ5
		swIntReq        ? swIntVector :    // RQ20
		breakpointInstr ? VEC_BREAKPOINT : // RQ21
		VEC_OVERFLOW;                      // RQ21

	// a combined debug event reports as a trap on the previous instruction
	assign pickClass =
		debugTrap  ? CLS_TRAP :  // RQ14
		debugFault ? CLS_FAULT :
		nmiTake    ? CLS_NMI :
		intrTake   ? CLS_MASKABLE_IRQ_IN :
		excReq     ? vec_class(excVector) : // RQ12
		CLS_TRAP; // RQ10

	// only the maskable request reads its vector from the controller
	assign pickNeedsAck = !debugAny && !nmiTake && intrTake; // RQ5

endmodule

`default_nettype wire

/* File: cpu_interrupt_exception_dispatch_asserts.sv */
/*
 * port assertions for the interrupt and exception dispatch unit.
 * bound to every instance of the unit; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module dispatch_checker (
	input wire logic                     core_clk,
	input wire logic                     resetn,
	input wire logic                     realMode,
	input wire logic [31:0]              tableBase,
	input wire logic [31:0]              instrAddr,
	input wire logic [31:0]              nextInstrAddr,
	input wire logic                     pushReq,
	input wire logic                     pushDone,
	input wire logic                     ackReq,
	input wire logic                     fetchReq,
	input wire logic                     fetchDone,
	input wire logic [31:0]              fetchAddr,
	input wire logic [31:0]              returnAddr,
	input wire logic                     savedIf,
	input wire logic                     ifFlag,
	input wire logic                     nmiActive,
	input wire logic                     dispatchValid,
	input wire logic [7:0]               dispatchVector,
	input wire irq_dispatch_pkg::class_e dispatchClass
);
	import irq_dispatch_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_nmi_vector: assert property (dispatchValid && dispatchClass == CLS_NMI |-> dispatchVector == 8'h02)
		else $error("nmi dispatched on wrong vector");
	a_nmi_no_ack: assert property (dispatchClass == CLS_NMI |-> !ackReq)
		else $error("acknowledge cycle run for nmi");
	a_ack_only_maskable_irq_in: assert property (ackReq |-> dispatchClass == CLS_MASKABLE_IRQ_IN)
		else $error("acknowledge cycle for non-maskable source");
	a_entry_clears_if: assert property ($rose(pushReq) |-> !ifFlag)
		else $error("enable flag still set after entry");
	a_maskable_irq_in_enabled: assert property ($rose(pushReq) && dispatchClass == CLS_MASKABLE_IRQ_IN |-> savedIf)
		else $error("maskable taken with flag clear");
	a_fault_return: assert property ($rose(pushReq) && dispatchClass == CLS_FAULT |->
		returnAddr == $past(instrAddr))
		else $error("fault return address not the faulting one");
	a_next_return: assert property ($rose(pushReq) && (dispatchClass inside {CLS_MASKABLE_IRQ_IN, CLS_NMI} ||
		(dispatchClass == CLS_TRAP && dispatchVector != 8'h01)) |-> returnAddr == $past(nextInstrAddr))
		else $error("return address not the next instruction");
	a_fetch_addr: assert property (fetchReq && $past(fetchReq) |->
		fetchAddr == tableBase + (32'(dispatchVector) << (realMode ? 2 : 3)))
		else $error("table entry address wrong");
	a_push_first: assert property (pushReq && pushDone |=> !pushReq && (ackReq || fetchReq))
		else $error("no vector or fetch step after push");
	a_fetch_start: assert property (fetchReq && fetchDone |=> dispatchValid && !fetchReq)
		else $error("handler not started after entry read");
	a_nmi_single: assert property ($rose(pushReq) && dispatchClass == CLS_NMI |-> !$past(nmiActive) && nmiActive)
		else $error("nmi taken while nmi handler active");
	a_double_abort: assert property (dispatchValid && dispatchVector == 8'h08 |-> dispatchClass == CLS_ABORT)
		else $error("double fault not an abort");
endmodule

bind cpu_interrupt_exception_dispatch dispatch_checker u_checker (.core_clk, .resetn, .realMode, .tableBase,
	.instrAddr, .nextInstrAddr, .pushReq, .pushDone, .ackReq, .fetchReq, .fetchDone, .fetchAddr, .returnAddr,
	.savedIf, .ifFlag, .nmiActive, .dispatchValid, .dispatchVector, .dispatchClass);

`default_nettype wire

/* File: irq_ctrl_model.sv */
/*
 * external interrupt controller: raises the maskable request, answers ack.
 * assumes the bench pulses raise with a vector; ACK_WAIT sets its speed.
 */
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl_model #(
	parameter int ACK_WAIT = 2
) (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       ackReq,
	input  wire logic       raise,
	input  wire logic [7:0] raiseVec,
	output logic            irqOut,
	output logic            ackValid,
	output logic [7:0]      ackVector
);
	int waitCnt;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irqOut <= 1'b0;
			ackValid <= 1'b0;
			ackVector <= 8'h5a;
			waitCnt <= 0;
		end else if (raise && !irqOut) begin
			irqOut <= 1'b1;
			ackVector <= raiseVec;
		end else if (ackValid && !ackReq) begin
			// released: vector no longer valid
			ackValid <= 1'b0;
			irqOut <= 1'b0;
			ackVector <= ~ackVector;
		end else if (irqOut && ackReq && !ackValid) begin
			waitCnt <= waitCnt + 1;
			if (waitCnt == ACK_WAIT) begin
				ackValid <= 1'b1;
				waitCnt <= 0;
			end
		end
	end
endmodule

`default_nettype wire

/* File: test_cpu_interrupt_exception_dispatch.sv */
/*
 * self-checking bench for the dispatch unit with a controller model.
 * clock and reset made here; core push and fetch handshakes served by tasks.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module test_cpu_interrupt_exception_dispatch;
	import irq_dispatch_pkg::*;
	logic        core_clk = 0;
	logic        resetn = 0;
	logic        nmiIn, instrBoundary, stringWindow, realMode, debugTrap, debugFault, excReq, swIntReq;
	logic        breakpointInstr, overflowInstr, overflowFlag, deliveryFault, pushDone, fetchDone;
	logic        interruptReturnInstr, restoredIf, ifWrite, ifWriteValue, raise;
	logic        maskableIrqIn, ackValid, pushReq, savedIf, ackReq, fetchReq, dispatchValid;
	logic        ifFlag, nmiActive, reservedVector;
	logic [7:0]  excVector, swIntVector, deliveryVector, raiseVec, ackVector, dispatchVector;
	logic [31:0] tableBase, instrAddr, nextInstrAddr, returnAddr, fetchAddr;
	class_e      dispatchClass;
	int          n_fail = 0;
	int          compares = 0;

	cpu_interrupt_exception_dispatch u_dut (.core_clk, .resetn, .nmiIn, .maskableIrqIn, .ackValid, .ackVector,
		.instrBoundary, .stringWindow, .realMode, .tableBase, .instrAddr, .nextInstrAddr, .debugTrap, .debugFault,
		.excReq, .excVector, .swIntReq, .swIntVector, .breakpointInstr, .overflowInstr, .overflowFlag,
		.deliveryFault, .deliveryVector, .pushDone, .fetchDone, .interruptReturnInstr, .restoredIf, .ifWrite,
		.ifWriteValue, .pushReq, .returnAddr, .savedIf, .ackReq, .fetchReq, .fetchAddr, .dispatchValid,
		.dispatchVector, .dispatchClass, .ifFlag, .nmiActive, .reservedVector);

	irq_ctrl_model #(.ACK_WAIT(2)) u_ctrl (.core_clk, .resetn, .ackReq, .raise, .raiseVec,
		.irqOut(maskableIrqIn), .ackValid, .ackVector);

	always #20 core_clk = ~core_clk;

	task automatic tally_and_finish;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// strobe a boundary, serve push and fetch, expect one dispatch
	task automatic runEv(input logic [7:0] expV, input class_e expC, input bit viaStr, input bit dFault);
		int i;
		bit fSeen;
		fSeen = 0;
		if (viaStr)
			stringWindow = 1;
		else
			instrBoundary = 1;
		@(posedge core_clk) #1;
		{instrBoundary, stringWindow, excReq, swIntReq, breakpointInstr, overflowInstr, debugTrap, debugFault} = '0;
		for (i = 0; i < 60 && !dispatchValid; i++) begin
			deliveryFault = pushReq && dFault && !pushDone;
			if (deliveryFault)
				dFault = 0;
			pushDone = pushReq && !pushDone && !deliveryFault;
			fetchDone = fetchReq && fSeen && !fetchDone;
			fSeen = fetchReq;
			@(posedge core_clk) #1;
		end
		{pushDone, fetchDone, deliveryFault} = '0;
		`CHK(dispatchValid, 1'b1)
		`CHK(dispatchVector, expV)
		`CHK(dispatchClass, expC)
		@(posedge core_clk) #1;
	endtask

	task automatic noTake(input bit viaStr);
		if (viaStr)
			stringWindow = 1;
		else
			instrBoundary = 1;
		repeat (4) begin
			@(posedge core_clk) #1;
			{instrBoundary, stringWindow} = '0;
			`CHK(pushReq, 1'b0)
		end
	endtask

	task automatic retIf;
		interruptReturnInstr = 1;
		restoredIf = 1;
		@(posedge core_clk) #1;
		interruptReturnInstr = 0;
		@(posedge core_clk) #1;
	endtask

	task automatic excTable;
		logic [7:0] v [12] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11};
		for (int k = 0; k < 12; k++) begin
			realMode = k[0];
			excReq = 1;
			excVector = v[k];
			runEv(v[k], v[k] == 8'h08 ? CLS_ABORT : CLS_FAULT, 0, 0);
		end
		excReq = 1;
		noTake(1);
		excReq = 0;
	endtask

	task automatic swTraps;
		logic [7:0] n [3] = '{8'h20, 8'hff, 8'h00};
		for (int k = 0; k < 3; k++) begin
			swIntReq = 1;
			swIntVector = n[k];
			runEv(n[k], CLS_TRAP, 0, 0);
		end
		breakpointInstr = 1;
		runEv(8'h03, CLS_TRAP, 0, 0);
		overflowInstr = 1;
		noTake(0);
		overflowFlag = 1;
		runEv(8'h04, CLS_TRAP, 0, 0);
		overflowFlag = 0;
		{debugFault, excReq} = 2'b11;
		excVector = 8'h06;
		runEv(8'h01, CLS_FAULT, 0, 0);
		{debugTrap, debugFault} = 2'b11;
		runEv(8'h01, CLS_TRAP, 0, 0);
	endtask

	task automatic maskable;
		raise = 1;
		raiseVec = 8'h41;
		@(posedge core_clk) #1;
		raise = 0;
		repeat (3) @(posedge core_clk) #1;
		noTake(0);
		ifWrite = 1;
		ifWriteValue = 1;
		@(posedge core_clk) #1;
		ifWrite = 0;
		runEv(8'h41, CLS_MASKABLE_IRQ_IN, 1, 0);
		`CHK(ifFlag, 1'b0)
		`CHK(savedIf, 1'b1)
		`CHK(reservedVector, 1'b0)
		retIf();
		`CHK(ifFlag, 1'b1)
	endtask

	task automatic nmiNest;
		raise = 1;
		raiseVec = 8'h1f;
		nmiIn = 1;
		@(posedge core_clk) #1;
		{raise, nmiIn} = '0;
		repeat (3) @(posedge core_clk) #1;
		runEv(8'h02, CLS_NMI, 0, 0);
		`CHK(nmiActive, 1'b1)
		`CHK(ifFlag, 1'b0)
		nmiIn = 1;
		@(posedge core_clk) #1;
		nmiIn = 0;
		repeat (3) @(posedge core_clk) #1;
		noTake(0);
		retIf();
		runEv(8'h02, CLS_NMI, 0, 0);
		retIf();
		runEv(8'h1f, CLS_MASKABLE_IRQ_IN, 0, 0);
		`CHK(reservedVector, 1'b1)
		retIf();
	endtask

	task automatic doubleFault;
		excReq = 1;
		excVector = 8'h0d;
		deliveryVector = 8'h0b;
		runEv(8'h08, CLS_ABORT, 0, 1);
		excReq = 1;
		excVector = 8'h0c;
		deliveryVector = 8'h0e;
		runEv(8'h0e, CLS_FAULT, 0, 1);
	endtask

	initial begin
		{nmiIn, instrBoundary, stringWindow, realMode, debugTrap, debugFault, excReq, swIntReq} = '0;
		{breakpointInstr, overflowInstr, overflowFlag, deliveryFault, pushDone, fetchDone} = '0;
		{interruptReturnInstr, restoredIf, ifWrite, ifWriteValue, raise} = '0;
		{excVector, swIntVector, deliveryVector, raiseVec} = '0;
		tableBase = 32'h0004_0000;
		instrAddr = 32'h0000_1230;
		nextInstrAddr = 32'h0000_1236;
		repeat (6) @(posedge core_clk);
		#1 resetn = 1;
		excTable();
		swTraps();
		maskable();
		nmiNest();
		doubleFault();
		tally_and_finish();
	end

	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
